// ==== inc/opsq_pkg.sv ====
// Purpose: Shared constants and types for the optical phase sequencer.
// Assumes: 200 MHz hclk, AHB-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package opsq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int LED_ON_NS = 100000;
  localparam int LED_ON_CYC = (LED_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRF_HZ = 100;
  localparam int PRF_PERIOD_CYC = 1000000000 / (PRF_HZ * CLK_PERIOD_NS);

  // ****************************************
  // Widths
  // ****************************************
  localparam int NPHASE = 4;
  localparam int RES_W = 24;
  localparam int CODE_W = 6;
  localparam int SEL_W = 3;
  localparam int OFFS_W = 5;
  localparam int CNT_W = 24;
  localparam int NLED = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LED = 8'h04;
  localparam logic [7:0] REG_TIA = 8'h08;
  localparam logic [7:0] REG_OFFS = 8'h0C;
  localparam logic [7:0] REG_PRF = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_LEDT = 8'h18;
  localparam logic [7:0] REG_RES0 = 8'h20;
  localparam logic [7:0] REG_RES3 = 8'h2C;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_THREE = 1;
  localparam int CTRL_X2 = 2;
  localparam int CTRL_SPLIT = 3;
  localparam int LED_STRIDE = 6;
  localparam int TRANSIMPEDANCE_GAIN_SELECT_LSB = 0;
  localparam int FEEDBACK_CAP_SELECT_LSB = 3;
  localparam int TIA_GAIN2_LSB = 6;
  localparam int TIA_CF2_LSB = 9;
  localparam int OFFS_STRIDE = 8;
  localparam int OFFS_POL_BIT = 7;
  localparam int STAT_PHASE_LSB = 0;
  localparam int STAT_ACTIVE = 2;
  localparam int STAT_CNT_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LED_RST = 32'h0000_0000;
  localparam logic [31:0] TIA_RST = 32'h0000_0000;
  localparam logic [31:0] OFFS_RST = 32'h0000_0000;

  // ****************************************
  // Phase tables
  // ****************************************
  // Bit n set: phase n uses the second capacitance set and the primary gain field.
  localparam logic [3:0] PHASE_SET2 = 4'h3;
  // LED enables per phase, bit 0 LED1, bit 1 LED2, bit 2 LED3.
  localparam logic [3:0][2:0] LED_MAP_TWO = {3'h0, 3'h1, 3'h0, 3'h2};
  localparam logic [3:0][2:0] LED_MAP_THREE = {3'h0, 3'h1, 3'h4, 3'h2};

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_LED = 3'h1,
    SEQ_RST = 3'h2,
    SEQ_WAIT = 3'h3,
    SEQ_GAP = 3'h4
  } opsq_state_e;

  typedef struct packed {
    logic active;
    logic [1:0] phase;
    logic led;
    logic rst;
    logic between;
  } opsq_seq_s;

  typedef struct packed {
    logic three;
    logic split;
    logic [SEL_W-1:0] gain;
    logic [SEL_W-1:0] cap;
    logic [SEL_W-1:0] gain2;
    logic [SEL_W-1:0] cap2;
  } opsq_cfg_s;

endpackage

// ==== verilog/opsq_seq.sv ====
// Purpose: Phase timing engine stepping four sampling phases per cycle.
// Assumes: Converter answers each conversion reset with conv_done.
// Notes: A cycle always runs to completion once started.
`timescale 1ns/1ps
module opsq_seq #(
  parameter int CW = 24
) (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic run, // Start and keep cycling.
  input wire logic [CW-1:0] led_cycles, // LED window length.
  input wire logic [CW-1:0] period, // Cycle length.
  input wire logic conv_done, // Conversion finished.
  output opsq_pkg::opsq_seq_s seq, // Sequence state.
  output logic store, // Store the current phase result.
  output logic cyc_done // One pulse per completed cycle.
);

  opsq_pkg::opsq_state_e state_q;
  logic [1:0] phase_q;
  logic [CW-1:0] led_cnt_q;
  logic [CW-1:0] per_cnt_q;
  logic per_end;

  assign per_end = per_cnt_q >= period - CW'(1);
  assign store = state_q == opsq_pkg::SEQ_WAIT && conv_done;
  assign cyc_done = store && phase_q == 2'h3;

  always_comb
  begin
    seq.active = state_q != opsq_pkg::SEQ_IDLE && state_q != opsq_pkg::SEQ_GAP;
    seq.phase = phase_q;
    seq.led = state_q == opsq_pkg::SEQ_LED;
    seq.rst = state_q == opsq_pkg::SEQ_RST;
    seq.between = state_q == opsq_pkg::SEQ_IDLE || state_q == opsq_pkg::SEQ_GAP;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= opsq_pkg::SEQ_IDLE;
      phase_q <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        opsq_pkg::SEQ_IDLE:
          if (run)
          begin
            state_q <= opsq_pkg::SEQ_LED;
            phase_q <= 2'h0;
          end
        opsq_pkg::SEQ_LED:
          if (led_cnt_q >= led_cycles - CW'(1))
            state_q <= opsq_pkg::SEQ_RST;
        opsq_pkg::SEQ_RST:
          state_q <= opsq_pkg::SEQ_WAIT;
        opsq_pkg::SEQ_WAIT:
          if (conv_done)
          begin
            state_q <= phase_q == 2'h3 ? opsq_pkg::SEQ_GAP : opsq_pkg::SEQ_LED;
            phase_q <= phase_q + 2'h1;
          end
        opsq_pkg::SEQ_GAP:
          if (per_end)
            state_q <= run ? opsq_pkg::SEQ_LED : opsq_pkg::SEQ_IDLE;
        default:
          state_q <= opsq_pkg::SEQ_IDLE;
      endcase
    end
  end

  // LED window counter restarts at every phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      led_cnt_q <= '0;
    else if (state_q == opsq_pkg::SEQ_LED)
      led_cnt_q <= led_cnt_q + CW'(1);
    else
      led_cnt_q <= '0;
  end

  // Cycle counter starts with phase 0 and spans the whole cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      per_cnt_q <= '0;
    else if (state_q == opsq_pkg::SEQ_IDLE || (state_q == opsq_pkg::SEQ_GAP && per_end))
      per_cnt_q <= '0;
    else
      per_cnt_q <= per_cnt_q + CW'(1);
  end

endmodule

// ==== verilog/opsq_top.sv ====
// Purpose: Optical phase sequencer with AHB-Lite register access.
// Assumes: One converter shared by four filter slots, results on conv_data.
// Notes: Reads take one wait state, writes none.
// Functional notes
// (R1) Four 24-bit results per cycle, own registers.
// (R2) One of four filter slots per phase.
// (R3) Conversion reset is union of phase pulses.
// (R4) Two-LED order: LED2, ambient2, LED1, ambient1.
// (R5) Three-LED order: LED2, LED3, LED1, ambient.
// (R6) Pulse each active LED only in its phase.
// (R7) Independent 6-bit current code per LED.
// (R8) Code is unsigned, 63 steps up to 50 mA.
// (R9) Range-double bit doubles LED current step.
// (R10) Default: one gain for all phases.
// (R11) Split: primary gain field drives second set.
// (R12) Each gain set has its own 3-bit field.
// (R13) Capacitance shared; split uses primary/separate fields.
// (R14) Four offset settings, active phase's presented.
// (R15) Results read as 24-bit two's complement.
// (R16) Fixed phase-to-set table, constant per cycle.
// (R17) Result written only after conversion completes.
`timescale 1ns/1ps
module opsq_top #(
  parameter int PRF_PERIOD_CYC = opsq_pkg::PRF_PERIOD_CYC,
  parameter int LED_ON_CYC = opsq_pkg::LED_ON_CYC,
  parameter int CNT_W = opsq_pkg::CNT_W
) (
  input wire logic hclk, // Clock, 200 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic [31:0] hrdata, // Read data.
  output logic hresp, // Response, always OKAY.
  input wire logic conv_done, // Converter finished a sample.
  input wire logic [opsq_pkg::RES_W-1:0] conv_data, // Sample, two's complement.
  output logic [opsq_pkg::NLED-1:0] led_on, // LED pulse, bit 0 LED1.
  output logic [opsq_pkg::NLED-1:0][opsq_pkg::CODE_W-1:0] led_current_code, // Per LED code.
  output logic led_range_double, // Doubles LED current range.
  output logic [opsq_pkg::NPHASE-1:0] filter_slot_sel, // One-hot filter slot.
  output logic [opsq_pkg::NPHASE-1:0] conversion_reset_phase, // Per-phase reset.
  output logic conversion_reset_pulse, // Composite reset.
  output logic [opsq_pkg::SEL_W-1:0] transimpedance_gain_select, // Gain code.
  output logic [opsq_pkg::SEL_W-1:0] feedback_cap_select, // Capacitance code.
  output logic [opsq_pkg::OFFS_W-1:0] offset_cancel_magnitude, // Offset size.
  output logic offset_cancel_polarity // Offset sign.
);

  if (CNT_W > 32 || LED_ON_CYC < 1 || PRF_PERIOD_CYC < 4 ||
      (CNT_W < 31 && (PRF_PERIOD_CYC >= (1 << CNT_W) || LED_ON_CYC >= (1 << CNT_W))))
  begin : g_chk
    $error("opsq_top: counter width or timing parameters out of range");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [2:0] led_map(input logic three, input logic [1:0] ph);
    led_map = three ? opsq_pkg::LED_MAP_THREE[ph] : opsq_pkg::LED_MAP_TWO[ph];
  endfunction

  function automatic logic [opsq_pkg::SEL_W-1:0] pick_gain(input opsq_pkg::opsq_cfg_s c,
                                                           input logic [1:0] ph);
    if (!c.split)
      pick_gain = c.gain;
    else if (opsq_pkg::PHASE_SET2[ph])
      pick_gain = c.gain;
    else
      pick_gain = c.gain2;
  endfunction

  function automatic logic [opsq_pkg::SEL_W-1:0] pick_cap(input opsq_pkg::opsq_cfg_s c,
                                                          input logic [1:0] ph);
    if (c.split && opsq_pkg::PHASE_SET2[ph])
      pick_cap = c.cap2;
    else
      pick_cap = c.cap;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_q;
  logic [31:0] led_q;
  logic [31:0] tia_q;
  logic [31:0] offs_q;
  logic [CNT_W-1:0] prf_q;
  logic [CNT_W-1:0] ledt_q;
  logic [opsq_pkg::RES_W-1:0] res_q [opsq_pkg::NPHASE];
  logic [15:0] cyc_cnt_q;
  opsq_pkg::opsq_cfg_s cfg_q;
  opsq_pkg::opsq_seq_s seq;
  logic store;
  logic cyc_done;

  // ****************************************
  // Bus slave
  // ****************************************
  logic acc;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic hit_q;
  logic [31:0] rd_d;

  assign acc = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hit_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= acc && hwrite;
      rd_pend_q <= acc && !hwrite;
      if (acc)
      begin
        addr_q <= {haddr[7:2], 2'h0};
        hit_q <= haddr[31:8] == 24'h00_0000 && hsize == 3'h2;
      end
    end
  end

  // Reads wait one cycle so a write just before is seen.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= !(acc && !hwrite);
      hresp <= 1'b0;
      if (rd_pend_q)
        hrdata <= rd_d;
    end
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (hit_q)
    begin
      unique case (addr_q)
        opsq_pkg::REG_CTRL: rd_d = ctrl_q;
        opsq_pkg::REG_LED: rd_d = led_q;
        opsq_pkg::REG_TIA: rd_d = tia_q;
        opsq_pkg::REG_OFFS: rd_d = offs_q;
        opsq_pkg::REG_PRF: rd_d = 32'(prf_q);
        opsq_pkg::REG_LEDT: rd_d = 32'(ledt_q);
        opsq_pkg::REG_STAT:
        begin
          rd_d[opsq_pkg::STAT_PHASE_LSB +: 2] = seq.phase;
          rd_d[opsq_pkg::STAT_ACTIVE] = seq.active;
          rd_d[opsq_pkg::STAT_CNT_LSB +: 16] = cyc_cnt_q;
        end
        default:
          if (addr_q >= opsq_pkg::REG_RES0 && addr_q <= opsq_pkg::REG_RES3)
            rd_d = 32'(res_q[addr_q[3:2]]); // R15
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= opsq_pkg::CTRL_RST;
      led_q <= opsq_pkg::LED_RST;
      tia_q <= opsq_pkg::TIA_RST;
      offs_q <= opsq_pkg::OFFS_RST;
      prf_q <= CNT_W'(PRF_PERIOD_CYC);
      ledt_q <= CNT_W'(LED_ON_CYC);
    end
    else if (wr_pend_q && hit_q)
    begin
      unique case (addr_q)
        opsq_pkg::REG_CTRL: ctrl_q <= hwdata & 32'h0000_000F;
        opsq_pkg::REG_LED: led_q <= hwdata & 32'h0003_FFFF; // R7
        opsq_pkg::REG_TIA: tia_q <= hwdata & 32'h0000_0FFF; // R12
        opsq_pkg::REG_OFFS: offs_q <= hwdata & 32'h9F9F_9F9F; // R14
        opsq_pkg::REG_PRF: prf_q <= hwdata[CNT_W-1:0];
        opsq_pkg::REG_LEDT: ledt_q <= hwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  opsq_seq #(
    .CW(CNT_W)
  ) u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ctrl_q[opsq_pkg::CTRL_RUN]),
    .led_cycles(ledt_q),
    .period(prf_q),
    .conv_done(conv_done),
    .seq(seq),
    .store(store),
    .cyc_done(cyc_done)
  );

  // Mode and gain fields are taken only between cycles.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg_q <= '0;
    else if (seq.between)
    begin
      cfg_q.three <= ctrl_q[opsq_pkg::CTRL_THREE]; // R16
      cfg_q.split <= ctrl_q[opsq_pkg::CTRL_SPLIT];
      cfg_q.gain <= tia_q[opsq_pkg::TRANSIMPEDANCE_GAIN_SELECT_LSB +: opsq_pkg::SEL_W];
      cfg_q.cap <= tia_q[opsq_pkg::FEEDBACK_CAP_SELECT_LSB +: opsq_pkg::SEL_W];
      cfg_q.gain2 <= tia_q[opsq_pkg::TIA_GAIN2_LSB +: opsq_pkg::SEL_W];
      cfg_q.cap2 <= tia_q[opsq_pkg::TIA_CF2_LSB +: opsq_pkg::SEL_W];
    end
  end

  // ****************************************
  // Results
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < opsq_pkg::NPHASE; i++)
        res_q[i] <= '0;
    end
    else if (store)
      res_q[seq.phase] <= conv_data; // R1 R17
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cyc_cnt_q <= 16'h0000;
    else if (cyc_done)
      cyc_cnt_q <= cyc_cnt_q + 16'h0001;
  end

  // ****************************************
  // Receiver and transmitter controls
  // ****************************************
  logic [opsq_pkg::NPHASE-1:0] rst_vec;
  logic [opsq_pkg::NPHASE-1:0] slot_vec;

  always_comb
  begin
    slot_vec = 4'h1 << seq.phase;
    rst_vec = seq.rst ? slot_vec : 4'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      led_on <= '0;
      filter_slot_sel <= 4'h0;
      conversion_reset_phase <= 4'h0;
      conversion_reset_pulse <= 1'b0;
    end
    else
    begin
      led_on <= seq.led ? led_map(cfg_q.three, seq.phase) : 3'h0; // R4 R5 R6
      filter_slot_sel <= seq.active ? slot_vec : 4'h0; // R2
      conversion_reset_phase <= rst_vec;
      conversion_reset_pulse <= |rst_vec; // R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      transimpedance_gain_select <= '0;
      feedback_cap_select <= '0;
    end
    else
    begin
      transimpedance_gain_select <= pick_gain(cfg_q, seq.phase); // R10 R11
      feedback_cap_select <= pick_cap(cfg_q, seq.phase); // R13
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      offset_cancel_magnitude <= '0;
      offset_cancel_polarity <= 1'b0;
    end
    else
    begin
      offset_cancel_magnitude <= offs_q[seq.phase * opsq_pkg::OFFS_STRIDE +: opsq_pkg::OFFS_W]; // R14
      offset_cancel_polarity <= offs_q[seq.phase * opsq_pkg::OFFS_STRIDE + opsq_pkg::OFFS_POL_BIT];
    end
  end

  // Codes pass as unsigned steps; range doubling scales every step.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      led_current_code <= '0;
      led_range_double <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < opsq_pkg::NLED; i++)
        led_current_code[i] <= led_q[i * opsq_pkg::LED_STRIDE +: opsq_pkg::CODE_W]; // R7 R8
      led_range_double <= ctrl_q[opsq_pkg::CTRL_X2]; // R9
    end
  end

endmodule

// ==== testbench/opsq_props.sv ====
// Purpose: Concurrent checks on the phase sequencer ports.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Attached to the top module by bind.
`timescale 1ns/1ps
module opsq_props (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic hready, // Bus ready.
  input wire logic hreadyout, // Slave ready.
  input wire logic [31:0] hrdata, // Read data.
  input wire logic hresp, // Response.
  input wire logic [2:0] led_on, // LED pulses.
  input wire logic [3:0] filter_slot_sel, // Filter slot.
  input wire logic [3:0] conversion_reset_phase, // Per-phase reset.
  input wire logic conversion_reset_pulse // Composite reset.
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic req_hit;
  assign req_hit = hsel && hready && htrans == 2'h2 && haddr[31:8] == 24'h000000;
  a_union_reset: assert property (conversion_reset_pulse == (|conversion_reset_phase)) else $error("composite reset");
  a_single_phase: assert property ($onehot0(conversion_reset_phase)) else $error("reset phases");
  a_pulse_short: assert property (conversion_reset_pulse |=> !conversion_reset_pulse) else $error("reset width");
  a_one_slot: assert property ($onehot0(filter_slot_sel)) else $error("slot select");
  a_led2_slot: assert property (led_on[1] |-> filter_slot_sel == 4'h1) else $error("led2 slot");
  a_led3_slot: assert property (led_on[2] |-> filter_slot_sel == 4'h2) else $error("led3 slot");
  a_led1_slot: assert property (led_on[0] |-> filter_slot_sel == 4'h4) else $error("led1 slot");
  a_led_reset: assert property ($fell(|led_on) |-> conversion_reset_pulse) else $error("led end");
  a_read_wait: assert property (req_hit && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_result_sign: assert property (req_hit && !hwrite && haddr[7:4] == 4'h2 |-> ##2 hrdata[31:24] == 8'h00)
    else $error("result upper");
  a_okay_resp: assert property (!hresp) else $error("response");
  c_led3: cover property (led_on[2]);
  c_phase3: cover property (conversion_reset_phase[3]);
  c_read: cover property (req_hit && !hwrite);
endmodule

bind opsq_top opsq_props opsq_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .led_on(led_on), .filter_slot_sel(filter_slot_sel), .conversion_reset_phase(conversion_reset_phase),
  .conversion_reset_pulse(conversion_reset_pulse));

// ==== testbench/opsq_conv.sv ====
// Purpose: Behavioural converter answering each conversion reset.
// Assumes: Phase is read from the one-hot filter slot at the reset pulse.
// Notes: Answers alternate between prompt and slow; idle data toggles.
`timescale 1ns/1ps
module opsq_conv (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic conversion_reset_pulse, // Start of conversion.
  input wire logic [3:0] filter_slot_sel, // Active slot.
  output logic conv_done, // Sample ready pulse.
  output logic [23:0] conv_data // Sample.
);
  // ****************************************
  // Conversion
  // ****************************************
  logic busy;
  logic slow;
  logic [3:0] cnt;
  logic [1:0] ph;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy <= 1'b0;
      slow <= 1'b0;
      cnt <= 4'h0;
      ph <= 2'h0;
      conv_done <= 1'b0;
      conv_data <= 24'h5A5A5A;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conversion_reset_pulse)
      begin
        busy <= 1'b1;
        cnt <= slow ? 4'h6 : 4'h0;
        slow <= ~slow;
        ph <= {filter_slot_sel[3] | filter_slot_sel[2], filter_slot_sel[3] | filter_slot_sel[1]};
      end
      else if (busy && cnt == 4'h0)
      begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= {22'h300000, ph};
      end
      else if (busy)
        cnt <= cnt - 4'h1;
    end
  end
endmodule

// ==== testbench/tb_opsq_top.sv ====
// Purpose: Self-checking bench for the phase sequencer.
// Assumes: Short cycle and LED window parameters.
// Notes: Register reads are noted in a queue and checked by a watcher.
`timescale 1ns/1ps
module tb_opsq_top;
  // ****************************************
  // Bench
  // ****************************************
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, conv_done, led_range_double, conversion_reset_pulse;
  logic offset_cancel_polarity, rd_pend, three, split;
  logic [31:0] haddr, hwdata, hrdata, led, offs, tia, v;
  logic [1:0] htrans, p, exp_ph;
  logic [2:0] hsize, led_on, led_seen, exp_led, transimpedance_gain_select, feedback_cap_select;
  logic [23:0] conv_data;
  logic [3:0] filter_slot_sel, conversion_reset_phase;
  logic [4:0] offset_cancel_magnitude;
  logic [2:0][5:0] led_current_code;
  logic [31:0] rq[$];
  integer seed = 32'h396b;
  int num_errors = 0, n_checks = 0, npulse = 0, cyc = 0, i;
  assign hready = hreadyout;
  opsq_top #(.PRF_PERIOD_CYC(200), .LED_ON_CYC(10)) opsq_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .conv_done(conv_done), .conv_data(conv_data),
    .led_on(led_on), .led_current_code(led_current_code), .led_range_double(led_range_double),
    .filter_slot_sel(filter_slot_sel), .conversion_reset_phase(conversion_reset_phase),
    .conversion_reset_pulse(conversion_reset_pulse), .transimpedance_gain_select(transimpedance_gain_select),
    .feedback_cap_select(feedback_cap_select), .offset_cancel_magnitude(offset_cancel_magnitude),
    .offset_cancel_polarity(offset_cancel_polarity));
  opsq_conv opsq_conv_i (.hclk(hclk), .hresetn(hresetn), .conversion_reset_pulse(conversion_reset_pulse),
    .filter_slot_sel(filter_slot_sel), .conv_done(conv_done), .conv_data(conv_data));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    xfer(a, 1'b0, 32'h00000000);
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  // Watches read answers and every phase at its conversion reset.
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout)
    begin
      chk(hrdata, rq.pop_front());
      rd_pend = 1'b0;
    end
    if (hsel && hready && htrans == 2'h2 && !hwrite)
      rd_pend = 1'b1;
    led_seen = led_seen | led_on;
    if (conversion_reset_pulse)
    begin
      p = {filter_slot_sel[3] | filter_slot_sel[2], filter_slot_sel[3] | filter_slot_sel[1]};
      exp_led = (p == 2'h0) ? 3'h2 : (p == 2'h2) ? 3'h1 : (p == 2'h1 && three) ? 3'h4 : 3'h0;
      chk(p, exp_ph);
      chk(conversion_reset_phase, filter_slot_sel);
      chk(led_seen, exp_led);
      chk({offset_cancel_polarity, offset_cancel_magnitude}, {offs[8*p+7], offs[8*p+:5]});
      chk(transimpedance_gain_select, (!split || p < 2'h2) ? tia[2:0] : tia[8:6]);
      chk(feedback_cap_select, (split && p < 2'h2) ? tia[11:9] : tia[5:3]);
      exp_ph = exp_ph + 2'h1;
      npulse++;
      led_seen = 3'h0;
    end
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rd_pend = 1'b0;
    led_seen = 3'h0;
    exp_ph = 2'h0;
    three = 1'b0;
    split = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 13; i++)
      rd(8'(i * 4), (i == 4) ? 32'h000000C8 : (i == 6) ? 32'h0000000A : 32'h00000000);
    for (i = 0; i < 2; i++)
    begin
      v = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      led = v & 32'h0003FFFF;
      xfer(8'h04, 1'b1, v);
      rd(8'h04, led);
      chk(led_current_code, led[17:0]);
    end
    v = $random(seed);
    offs = v & 32'h9F9F9F9F;
    xfer(8'h0C, 1'b1, v);
    rd(8'h0C, offs);
    v = $random(seed);
    tia = v & 32'h00000FFF;
    xfer(8'h08, 1'b1, v);
    rd(8'h08, tia);
    xfer(8'h20, 1'b1, 32'h12345678);
    rd(8'h20, 32'h00000000);
    xfer(8'h00, 1'b1, 32'h00000001);
    while (npulse < 8) @(posedge hclk);
    chk(led_range_double, 1'b0);
    xfer(8'h00, 1'b1, 32'h00000000);
    repeat (300) @(posedge hclk);
    chk(npulse, 8);
    for (i = 0; i < 4; i++)
      rd(8'(32 + i * 4), 32'h00C00000 | i);
    rd(8'h14, 32'h00020000);
    three = 1'b1;
    split = 1'b1;
    xfer(8'h00, 1'b1, 32'h0000000F);
    repeat (2) @(posedge hclk);
    chk(led_range_double, 1'b1);
    while (npulse < 16) @(posedge hclk);
    xfer(8'h00, 1'b1, 32'h00000000);
    repeat (300) @(posedge hclk);
    chk(npulse, 16);
    rd(8'h14, 32'h00040000);
    while (rq.size() != 0) @(posedge hclk);
    results();
  end
endmodule
